// File: bench/abe_exec_checker.sv
// assertions on the ports of the add/and/bit executor
// assumes one clock domain, synchronous active-low reset
`timescale 1ns/100ps
module abe_exec_checker (
    // clock and reset
    input wire logic                        i_clk,
    input wire logic                        i_rstn,
    // instruction stream
    input wire logic                        i_instr_valid,
    input wire logic [abe_pkg::INSTR_W-1:0] i_instr,
    // outputs under watch
    input wire logic [abe_pkg::DATA_W-1:0]  o_acc,
    input wire logic                        o_flag_zero,
    input wire logic                        o_flag_carry,
    input wire logic                        o_nibble_overflow_flag,
    input wire logic                        o_skip,
    input wire logic                        o_done,
    input wire logic                        o_file_we,
    input wire logic [abe_pkg::FADDR_W-1:0] o_file_addr
);
    import abe_pkg::*;
    logic pend_reg;
    logic take;
    logic byte_op;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // a skip stays pending over idle cycles until a valid word arrives
    always_ff @(posedge i_clk) begin
        if (!i_rstn)
            pend_reg <= 1'b0;
        else if (i_instr_valid)
            pend_reg <= 1'b0;
        else if (o_skip)
            pend_reg <= 1'b1;
    end
    // words that really execute
    assign take = i_instr_valid && !o_skip && !pend_reg;
    assign byte_op = take && (i_instr[13:8] == OPC_ADD_FILE || i_instr[13:8] == OPC_AND_FILE);
    property p_add_imm; take && i_instr[13:8] == OPC_ADD_IMM |=> {o_flag_carry, o_acc} ==
        {1'b0, $past(o_acc)} + {1'b0, $past(i_instr[7:0])} && o_flag_zero == (o_acc == 8'h00);
    endproperty
    a_add_imm: assert property (p_add_imm) else $error("add immediate result wrong");
    property p_add_nib; take && i_instr[13:8] == OPC_ADD_IMM |=> o_nibble_overflow_flag ==
        ({1'b0, $past(o_acc[3:0])} + {1'b0, $past(i_instr[3:0])} > 5'h0f);
    endproperty
    a_add_nib: assert property (p_add_nib) else $error("nibble carry wrong");
    property p_and_imm; take && i_instr[13:8] == OPC_AND_IMM |=> o_acc == ($past(o_acc) &
        $past(i_instr[7:0])) && $stable(o_flag_carry) && $stable(o_nibble_overflow_flag);
    endproperty
    a_and_imm: assert property (p_and_imm) else $error("and immediate wrong");
    property p_to_acc; byte_op && !i_instr[POS_DEST] |=> !o_file_we; endproperty
    a_to_acc: assert property (p_to_acc) else $error("file written for d=0");
    property p_to_file; byte_op && i_instr[POS_DEST] |=> o_file_we &&
        o_file_addr == $past(i_instr[6:0]) && $stable(o_acc);
    endproperty
    a_to_file: assert property (p_to_file) else $error("d=1 write wrong");
    property p_and_file; take && i_instr[13:8] == OPC_AND_FILE |=> $stable(o_flag_carry) &&
        $stable(o_nibble_overflow_flag);
    endproperty
    a_and_file: assert property (p_and_file) else $error("and file touched carries");
    property p_bit_op; take && (i_instr[13:9] == OPC_BIT_CLR || i_instr[13:9] == OPC_BIT_SET)
        |=> o_file_we && o_file_addr == {1'b0, $past(i_instr[5:0])} && $stable(o_acc) &&
        $stable(o_flag_zero) && $stable(o_flag_carry) && $stable(o_nibble_overflow_flag);
    endproperty
    a_bit_op: assert property (p_bit_op) else $error("bit op wrong");
    property p_skip_src; take && i_instr[13:9] != OPC_BIT_TSTZ |=> !o_skip; endproperty
    a_skip_src: assert property (p_skip_src) else $error("skip from non-test");
    property p_discard; i_instr_valid && (o_skip || pend_reg) |=> $stable(o_acc) &&
        !o_file_we && !o_skip && o_done;
    endproperty
    a_discard: assert property (p_discard) else $error("skipped word ran");
endmodule
bind abe_exec abe_exec_checker u_chk (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_instr_valid(i_instr_valid), .i_instr(i_instr), .o_acc(o_acc),
    .o_flag_zero(o_flag_zero), .o_flag_carry(o_flag_carry), .o_skip(o_skip),
    .o_nibble_overflow_flag(o_nibble_overflow_flag), .o_done(o_done),
    .o_file_we(o_file_we), .o_file_addr(o_file_addr));

// File: bench/abe_exec_tb.sv
// self-checking bench for the add/and/bit executor
// assumes the checker is bound to the design
`timescale 1ns/100ps
module abe_exec_tb;
    import abe_pkg::*;
    logic       i_clk = 1'b0;
    logic       i_rstn;
    logic       i_instr_valid;
    logic [13:0] i_instr;
    logic [7:0] o_acc, o_file_wdata;
    logic       o_flag_zero, o_flag_carry, o_nibble_overflow_flag, o_skip, o_done, o_file_we;
    logic [6:0] o_file_addr;
    int         num_errors = 0;
    int         comparisons = 0;
    logic [33:0] r;
    // rows: word, acc, zero/carry/nibble, write, write data
    localparam logic [33:0] ROWS [14] = '{
        {14'h1c10, 8'h10, 3'h0, 9'h000}, {14'h1c15, 8'h25, 3'h0, 9'h000},
        {14'h1cfe, 8'h23, 3'h3, 9'h000}, {14'h1b5f, 8'h03, 3'h3, 9'h000},
        {14'h1b00, 8'h00, 3'h7, 9'h000}, {14'h1c17, 8'h17, 3'h0, 9'h000},
        {14'h13c5, 8'h17, 3'h0, 9'h180}, {14'h1385, 8'h17, 3'h0, 9'h1c0},
        {14'h1245, 8'h17, 3'h0, 9'h1c2}, {14'h0585, 8'h17, 3'h0, 9'h102},
        {14'h0785, 8'h17, 3'h0, 9'h119}, {14'h0705, 8'h30, 3'h1, 9'h000},
        {14'h1105, 8'h30, 3'h1, 9'h109}, {14'h0505, 8'h00, 3'h5, 9'h000}};
    abe_exec u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_instr_valid(i_instr_valid),
        .i_instr(i_instr), .o_acc(o_acc), .o_flag_zero(o_flag_zero),
        .o_flag_carry(o_flag_carry), .o_nibble_overflow_flag(o_nibble_overflow_flag),
        .o_skip(o_skip), .o_done(o_done), .o_file_we(o_file_we),
        .o_file_addr(o_file_addr), .o_file_wdata(o_file_wdata));
    // clock
    always #12.5 i_clk = ~i_clk;
    // compare and count
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one word for one cycle, then settle past the answering edge
    task automatic issue(input logic [13:0] w);
        @(posedge i_clk);
        i_instr_valid <= 1'b1;
        i_instr <= w;
        @(posedge i_clk);
        i_instr_valid <= 1'b0;
        #1;
    endtask
    task automatic final_report;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // main sequence
    initial begin
        i_rstn = 1'b0;
        i_instr_valid = 1'b0;
        i_instr = 14'h0000;
        repeat (5) @(posedge i_clk);
        #1;
        check("acc", o_acc, ACC_RST);
        // release at the sixth edge, by non-blocking assignment on it
        @(posedge i_clk);
        i_rstn <= 1'b1;
        // clear every bit of file 05 so its contents are known
        for (int b = 0; b < 8; b++) begin
            issue(14'(14'h1005 | (b << 6)));
        end
        check("wdata", o_file_wdata, 8'h00);
        check("addr", {1'b0, o_file_addr}, 8'h05);
        for (int i = 0; i < 14; i++) begin
            r = ROWS[i];
            issue(r[33:20]);
            check("acc", o_acc, r[19:12]);
            check("flags", {5'h00, o_flag_zero, o_flag_carry, o_nibble_overflow_flag},
                {5'h00, r[11:9]});
            check("we", {7'h00, o_file_we}, {7'h00, r[8]});
            if (r[8]) begin
                check("wdata", o_file_wdata, r[7:0]);
                check("addr", {1'b0, o_file_addr}, 8'h05);
            end
        end
        issue(14'h14c5);
        check("skip", {7'h00, o_skip}, 8'h00);
        issue(14'h1445);
        check("skip", {7'h00, o_skip}, 8'h01);
        issue(14'h1c01);
        check("done", {7'h00, o_done}, 8'h01);
        check("acc", o_acc, 8'h00);
        issue(14'h1c01);
        check("acc", o_acc, 8'h01);
        // leave a skip pending, then reset in mid-run; reset must drop it
        issue(14'h1445);
        check("skip", {7'h00, o_skip}, 8'h01);
        @(posedge i_clk);
        i_rstn <= 1'b0;
        @(posedge i_clk);
        #1;
        check("acc", o_acc, ACC_RST);
        check("skip", {7'h00, o_skip}, 8'h00);
        @(posedge i_clk);
        i_rstn <= 1'b1;
        issue(14'h1c01);
        check("acc", o_acc, 8'h01);
        check("done", {7'h00, o_done}, 8'h01);
        final_report();
    end
endmodule

// File: rtl/abe_alu.sv
// combinational arithmetic unit: add, and, single-bit clear and set
// assumes operands arrive from the executor through abe_alu_if
`timescale 1ns/100ps
module abe_alu (
    abe_alu_if.unit alu
);
    import abe_pkg::*;

    logic [DATA_W:0]   sum;
    logic [4:0]        low_sum;
    logic [DATA_W-1:0] onehot;

    // full and low-nibble sums give the two carry flags
    assign sum = {1'b0, alu.opa} + {1'b0, alu.opb};
    assign low_sum = {1'b0, alu.opa[3:0]} + {1'b0, alu.opb[3:0]};
    assign onehot = 8'h01 << alu.bitsel;

    // result selection per operation
    always_comb begin
        alu.result = alu.opa;
        alu.carry = 1'b0;
        alu.nibble = 1'b0;
        unique case (alu.op)
            ABE_ALU_ADD: begin
                alu.result = sum[DATA_W-1:0];
                alu.carry = sum[POS_CARRY+1];
                alu.nibble = low_sum[POS_NIBBLE+1];
            end
            ABE_ALU_AND: begin
                alu.result = alu.opa & alu.opb;
            end
            ABE_ALU_BCLR: begin
                alu.result = alu.opa & ~onehot;
            end
            ABE_ALU_BSET: begin
                alu.result = alu.opa | onehot;
            end
        endcase
        alu.zero = (alu.result == 8'h00);
    end
endmodule

// File: rtl/abe_exec.sv
// executor for add-immediate, add-file, and-immediate, and-file, bit clear,
// bit set and bit test with skip-if-zero, holding the accumulator, the flags
// and a 128-byte register file
// assumes the fetch logic offers one instruction per cycle on i_instr_valid and
// still offers the instruction after a taken test, which is discarded here; other opcodes are ignored
`timescale 1ns/100ps
module abe_exec (
    // clock and reset
    input  wire logic                          i_clk,
    input  wire logic                          i_rstn,
    // instruction stream
    input  wire logic                          i_instr_valid,
    input  wire logic [abe_pkg::INSTR_W-1:0]   i_instr,
    // core state
    output logic      [abe_pkg::DATA_W-1:0]    o_acc,
    output logic                               o_flag_zero,
    output logic                               o_flag_carry,
    output logic                               o_nibble_overflow_flag,
    // program-counter skip and completion
    output logic                               o_skip,
    output logic                               o_done,
    // register file write report
    output logic                               o_file_we,
    output logic      [abe_pkg::FADDR_W-1:0]   o_file_addr,
    output logic      [abe_pkg::DATA_W-1:0]    o_file_wdata
);
    import abe_pkg::*;

    // operand and result bundle to the arithmetic unit
    abe_alu_if alu_bus ();

    logic [DATA_W-1:0]  file_mem [FILE_DEPTH];
    logic [DATA_W-1:0]  acc_reg;
    logic               zero_reg;
    logic               carry_reg;
    logic               nibble_reg;
    logic               skip_reg;
    logic               done_reg;
    logic               we_reg;
    logic [FADDR_W-1:0] waddr_reg;
    logic [DATA_W-1:0]  wdata_reg;
    abe_state_t         state_reg;
    abe_state_t         state_next;

    // decoded fields
    logic               add_imm_to_acc;
    logic               add_acc_file;
    logic               and_imm_to_acc;
    logic               and_acc_file;
    logic               bit_clear_op;
    logic               bit_set_op;
    logic               bit_test_skip_if_zero;
    logic               dest_bit;
    logic [FADDR_W-1:0] faddr;
    logic [2:0]         bitsel;
    logic [DATA_W-1:0]  file_rd;
    logic               live;
    logic               byte_op;
    logic               bit_op;
    logic               skip_hit;

    // a discarded instruction is never executed
    assign live = i_instr_valid && (state_reg == ABE_ST_RUN);

    // opcode decode; words outside these seven patterns change nothing
    // and still pulse the completion flag, so fetch never stalls on them
    assign add_imm_to_acc = live && (i_instr[13:8] == OPC_ADD_IMM);
    assign add_acc_file = live && (i_instr[13:8] == OPC_ADD_FILE);
    assign and_imm_to_acc = live && (i_instr[13:8] == OPC_AND_IMM);
    assign and_acc_file = live && (i_instr[13:8] == OPC_AND_FILE);
    assign bit_clear_op = live && (i_instr[13:9] == OPC_BIT_CLR);
    assign bit_set_op = live && (i_instr[13:9] == OPC_BIT_SET);
    assign bit_test_skip_if_zero = live && (i_instr[13:9] == OPC_BIT_TSTZ);

    // operand fields; bit operations reach only the low 64 addresses
    assign dest_bit = i_instr[POS_DEST];
    assign bitsel = i_instr[POS_BITSEL +: BITSEL_W];
    assign faddr = (bit_clear_op || bit_set_op || bit_test_skip_if_zero)
                 ? {1'b0, i_instr[5:0]} : i_instr[FADDR_W-1:0];
    assign file_rd = file_mem[faddr];
    assign byte_op = add_acc_file || and_acc_file;
    assign bit_op = bit_clear_op || bit_set_op;
    assign skip_hit = bit_test_skip_if_zero && !file_rd[bitsel];

    // operand steering to the arithmetic unit; addition is the default, and
    // bit operations feed the file byte in place of the accumulator
    always_comb begin
        alu_bus.op = ABE_ALU_ADD;
        alu_bus.opa = acc_reg;
        alu_bus.opb = file_rd;
        alu_bus.bitsel = bitsel;
        if (add_imm_to_acc) begin
            alu_bus.opb = i_instr[DATA_W-1:0];
        end else if (and_imm_to_acc) begin
            alu_bus.op = ABE_ALU_AND;
            alu_bus.opb = i_instr[DATA_W-1:0];
        end else if (and_acc_file) begin
            alu_bus.op = ABE_ALU_AND;
        end else if (bit_clear_op) begin
            alu_bus.op = ABE_ALU_BCLR;
            alu_bus.opa = file_rd;
        end else if (bit_set_op) begin
            alu_bus.op = ABE_ALU_BSET;
            alu_bus.opa = file_rd;
        end
    end

    abe_alu u_alu (
        .alu (alu_bus)
    );

    // accumulator update
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            acc_reg <= ACC_RST;
        end else if (add_imm_to_acc || and_imm_to_acc) begin
            acc_reg <= alu_bus.result;
        end else if (byte_op && dest_bit == DEST_ACC) begin
            acc_reg <= alu_bus.result;
        end
    end

    // zero flag: every add and and operation; it follows the result whichever
    // destination the result is routed to
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            zero_reg <= FLAG_RST;
        end else if (add_imm_to_acc || add_acc_file || and_imm_to_acc || and_acc_file) begin
            zero_reg <= alu_bus.zero;
        end
    end

    // carry flags: additions only, bit operations leave all flags alone
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            carry_reg <= FLAG_RST;
            nibble_reg <= FLAG_RST;
        end else if (add_imm_to_acc || add_acc_file) begin
            carry_reg <= alu_bus.carry;
            nibble_reg <= alu_bus.nibble;
        end
    end

    // register file write-back; contents hold no reset value beyond power-up
    // a write lands at the edge, so a read of the same byte one instruction
    // later already sees the new value
    always_ff @(posedge i_clk) begin
        if ((byte_op && dest_bit == DEST_FILE) || bit_op) begin
            file_mem[faddr] <= alu_bus.result;
        end
    end

    // write report for the surrounding core
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            we_reg <= 1'b0;
            waddr_reg <= '0;
            wdata_reg <= FILE_RST;
        end else begin
            we_reg <= (byte_op && dest_bit == DEST_FILE) || bit_op;
            waddr_reg <= faddr;
            wdata_reg <= alu_bus.result;
        end
    end

    // skip sequencer: a taken test turns the next instruction into a no-op
    // the skip state waits through idle cycles, so a fetch stall between the
    // test and its successor cannot let the discarded word run; reset drops it
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ABE_ST_RUN: begin
                if (skip_hit) begin
                    state_next = ABE_ST_SKIP;
                end
            end
            ABE_ST_SKIP: begin
                if (i_instr_valid) begin
                    state_next = ABE_ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            state_reg <= ABE_ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // skip and completion pulses; a discarded word still reports completion
    // so the fetch side can count every word it offered
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            skip_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            skip_reg <= skip_hit;
            done_reg <= i_instr_valid;
        end
    end

    assign o_acc = acc_reg;
    assign o_flag_zero = zero_reg;
    assign o_flag_carry = carry_reg;
    assign o_nibble_overflow_flag = nibble_reg;
    assign o_skip = skip_reg;
    assign o_done = done_reg;
    assign o_file_we = we_reg;
    assign o_file_addr = waddr_reg;
    assign o_file_wdata = wdata_reg;
endmodule

// File: shared/abe_alu_if.sv
// operand and result bundle between the executor and its arithmetic unit
// assumes both ends sit in the same clock domain; the unit is combinational
`timescale 1ns/100ps
interface abe_alu_if;
    import abe_pkg::*;
    abe_alu_op_t       op;
    logic [DATA_W-1:0] opa;
    logic [DATA_W-1:0] opb;
    logic [2:0]        bitsel;
    logic [DATA_W-1:0] result;
    logic              carry;
    logic              nibble;
    logic              zero;

    modport exec (output op, opa, opb, bitsel, input result, carry, nibble, zero);
    modport unit (input op, opa, opb, bitsel, output result, carry, nibble, zero);
endinterface

// File: shared/abe_pkg.sv
// constants, opcode patterns and operation codes for the add/and/bit executor
// assumes a 14-bit instruction word and an 8-bit data path
package abe_pkg;
    localparam int DATA_W  = 8;
    localparam int INSTR_W = 14;
    localparam int FADDR_W = 7;
    localparam int FILE_DEPTH = 128;
    localparam int BITSEL_W = 3;

    // byte-oriented and literal patterns, instruction bits 13..8
    localparam logic [5:0] OPC_ADD_IMM = 6'h1c;   // 01 1100
    localparam logic [5:0] OPC_AND_IMM = 6'h1b;   // 01 1011
    localparam logic [5:0] OPC_ADD_FILE = 6'h07;  // 00 0111
    localparam logic [5:0] OPC_AND_FILE = 6'h05;  // 00 0101
    // bit-oriented patterns, instruction bits 13..9
    localparam logic [4:0] OPC_BIT_CLR = 5'h08;   // 01 000
    localparam logic [4:0] OPC_BIT_SET = 5'h09;   // 01 001
    localparam logic [4:0] OPC_BIT_TSTZ = 5'h0a;  // 01 010

    // field positions
    localparam int POS_DEST = 7;
    localparam int POS_BITSEL = 6;
    localparam int POS_CARRY = 7;
    localparam int POS_NIBBLE = 3;

    // values after reset
    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
    localparam logic [DATA_W-1:0] FILE_RST = 8'h00;
    localparam logic              FLAG_RST = 1'b0;

    // destination selector values
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    typedef enum logic [1:0] {
        ABE_ALU_ADD,
        ABE_ALU_AND,
        ABE_ALU_BCLR,
        ABE_ALU_BSET
    } abe_alu_op_t;

    typedef enum {
        ABE_ST_RUN,
        ABE_ST_SKIP
    } abe_state_t;
endpackage
